/* File: core/pawb_pkg.sv */
// Shared constants, types and register map of the access wait bridge
package pawb_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] PAWB_OFF_WAIT_SET = 8'h00; // Bus wait setting
  localparam logic [7:0] PAWB_OFF_CLK_CFG = 8'h04; // Clock ratio config
  localparam logic [7:0] PAWB_OFF_STATUS = 8'h08; // Bridge status
  localparam logic [7:0] PAWB_OFF_LAST = 8'h0C; // Last access length

  // Reset values
  localparam logic [7:0] PAWB_WAIT_SET_RST = 8'h77;
  localparam logic [7:0] PAWB_MAIN_DIV_RST = 8'h04; // Main period in CPU clk
  localparam logic [7:0] PAWB_RTO_EN_RST = 8'h00;

  // Field positions
  localparam int PAWB_M_LSB = 0; // Base wait field, bits 2..0
  localparam int PAWB_M_W = 3;
  localparam int PAWB_RTO_EN_BIT = 8; // Real-time output enable bit
  localparam int PAWB_OSC_OK_BIT = 9; // Main oscillator status

  // Fixed access cost with no wait
  localparam logic [7:0] PAWB_BASE_CYC = 8'h03;
  localparam logic [7:0] PAWB_PAIR_CYC = 8'h02;

  // Peripheral register selects presented by the CPU core
  typedef enum logic [4:0] {
    PAWB_REG_OTHER = 5'h00,
    PAWB_REG_WDOG1_MODE = 5'h01,
    PAWB_REG_WDOG2_MODE = 5'h02,
    PAWB_REG_TA_CC0 = 5'h03,
    PAWB_REG_TA_CC1 = 5'h04,
    PAWB_REG_TA_CNT = 5'h05,
    PAWB_REG_TB_CTRL = 5'h06,
    PAWB_REG_TWO_WIRE_ST = 5'h07,
    PAWB_REG_SER0_RX_ST = 5'h08,
    PAWB_REG_SER1_RX_ST = 5'h09,
    PAWB_REG_RT_BUF_LO = 5'h0A,
    PAWB_REG_RT_BUF_HI = 5'h0B,
    PAWB_REG_ADC_MODE = 5'h0C,
    PAWB_REG_ADC_CHSEL = 5'h0D,
    PAWB_REG_ADC_CMP_MODE = 5'h0E,
    PAWB_REG_ADC_CMP_THR = 5'h0F,
    PAWB_REG_ADC_RESULT = 5'h10,
    PAWB_REG_ADC_RESULT_HI = 5'h11
  } pawb_reg_t;

  // Access kinds
  typedef enum logic [1:0] {
    PAWB_ACC_READ = 2'h0,
    PAWB_ACC_WRITE = 2'h1,
    PAWB_ACC_RMW = 2'h2
  } pawb_acc_t;

  // One CPU access request
  typedef struct packed {
    pawb_reg_t sel;
    pawb_acc_t kind;
  } pawb_req_t;

endpackage : pawb_pkg

/* File: core/pawb_kcalc.sv */
// Wait factor and wait count calculator for one access
`timescale 1ns/1ps
module pawb_kcalc
  import pawb_pkg::*;
(
  input wire pawb_req_t req_i,
  input wire logic [2:0] m_i,
  input wire logic [7:0] main_div_i,
  input wire logic rto_en_i,
  output logic [7:0] extra_o,
  output logic [7:0] total_o
);

  // Ceil-like division with the threshold rounding of the factor
  function automatic logic [7:0] pawb_kdiv(input logic [7:0] num,
                                           input logic [7:0] den);
    logic [7:0] q;
    logic [7:0] r;
    begin
      q = num / den;
      r = num % den;
      // Fraction beyond 1/(2+m) of a CPU period rounds up
      if (r > 8'h01) begin
        q = q + 8'h01;
      end
      pawb_kdiv = q;
    end
  endfunction : pawb_kdiv

  logic [7:0] pair; // 2 + m
  logic [7:0] k;

  // Factor per register and access kind
  always_comb begin
    pair = PAWB_PAIR_CYC + {5'h00, m_i};
    k = 8'h00;
    case (req_i.sel)
      PAWB_REG_WDOG1_MODE: begin
        if (req_i.kind != PAWB_ACC_READ) begin
          k = pawb_kdiv({main_div_i[6:0], 1'b0}, pair) + 8'h01;
        end
      end
      PAWB_REG_WDOG2_MODE: begin
        if (req_i.kind != PAWB_ACC_READ) begin
          k = 8'h03;
        end
      end
      PAWB_REG_TA_CC0, PAWB_REG_TA_CC1: begin
        if (req_i.kind == PAWB_ACC_READ) begin
          k = 8'h01;
        end else begin
          k = pawb_kdiv(8'(main_div_i * 8'h05), pair);
          if (k > 8'h02) begin
            k = 8'h02;
          end
        end
      end
      PAWB_REG_TA_CNT: begin
        if (req_i.kind == PAWB_ACC_READ) begin
          k = 8'h01;
        end
      end
      PAWB_REG_TB_CTRL: begin
        if (req_i.kind == PAWB_ACC_RMW) begin
          k = 8'h01; // Write phase only
        end
      end
      PAWB_REG_TWO_WIRE_ST, PAWB_REG_SER0_RX_ST,
      PAWB_REG_SER1_RX_ST: begin
        if (req_i.kind == PAWB_ACC_READ) begin
          k = 8'h01;
        end
      end
      PAWB_REG_RT_BUF_LO, PAWB_REG_RT_BUF_HI: begin
        if (req_i.kind != PAWB_ACC_READ && !rto_en_i) begin
          k = 8'h01;
        end
      end
      PAWB_REG_ADC_MODE, PAWB_REG_ADC_CHSEL, PAWB_REG_ADC_CMP_MODE,
      PAWB_REG_ADC_CMP_THR: begin
        if (req_i.kind != PAWB_ACC_READ) begin
          k = pawb_kdiv({main_div_i[6:0], 1'b0}, pair) + 8'h01;
        end
      end
      PAWB_REG_ADC_RESULT, PAWB_REG_ADC_RESULT_HI: begin
        if (req_i.kind == PAWB_ACC_READ) begin
          k = pawb_kdiv({main_div_i[6:0], 1'b0}, pair) + 8'h01;
        end
      end
      default: begin
        k = 8'h00; // Ordinary register
      end
    endcase
    extra_o = 8'(pair * k);
    total_o = 8'(PAWB_BASE_CYC + {5'h00, m_i} + extra_o);
  end

endmodule : pawb_kcalc

/* File: core/pawb_bridge.sv */
// Peripheral access wait bridge: CPU stall control and Wishbone registers
// Notes on behaviour
// - Stretch conflict-prone accesses, stalling CPU
// - CPU held; time grows by waits
// - Extra waits equal (2+m) times k
// - Total access is 3+m+extra
// - m is low three setting bits
// - First watchdog write: k from ratio
// - Second watchdog write: k is three
// - Timer A reads: k is one
// - Timer A compare writes: k 0..2
// - Timer B RMW: k one, write
// - Serial and two-wire status reads: k one
// - RT buffer writes: k one when disabled
// - ADC setting writes and result reads: k from ratio plus one
// - Fraction over 1/(2+m) rounds up
// - Counts are maxima, exceeded only by a stuck stall
// - Stall sticks without oscillator until reset
// - Ordinary access: three plus base wait
`timescale 1ns/1ps
module pawb_bridge
  import pawb_pkg::*;
(
  // Clock and synchronous reset, active high
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // CPU peripheral access side
  // One access at a time; ready low stalls the CPU
  input wire logic cpu_req_i,
  input wire pawb_req_t cpu_acc_i,
  output logic cpu_ready_o,
  output logic cpu_done_o,
  // Peripheral side
  // Oscillator status decides between a wait and a stall
  input wire logic main_osc_ok_i,
  output logic periph_stb_o,
  output pawb_req_t periph_acc_o,
  output logic stuck_o
);

  // Bridge states
  // Idle: waiting for an access; busy: counting it down
  // Stuck: dead end of a wait that needs the absent main clock
  // No way out but reset, as the far side cannot answer then
  typedef enum logic [1:0] {
    PAWB_ST_IDLE = 2'h0,
    PAWB_ST_BUSY = 2'h1,
    PAWB_ST_STUCK = 2'h2
  } pawb_state_t;

  // Software settings
  // Written over the register bus only
  // Wait setting resets slow, safe at any clock until lowered
  logic [7:0] bus_wait_setting; // Bus wait setting
  logic [7:0] main_div; // Main clock period in CPU clocks
  logic rt_output_enable_bit; // Real-time output enable
  logic [7:0] next_bus_wait_setting;
  logic [7:0] next_main_div;
  logic next_rt_output_enable_bit;

  // Wishbone answer
  // Data and ack leave flops: one cycle latency, no glitches
  // Trade-off accepted as software reads these rarely
  logic [31:0] next_wb_dat;
  logic next_wb_ack;

  // Access engine
  // Counter holds cycles left in the access
  // Loaded with the length less the taking cycle
  // Ending on a compare with one saves a second adder
  pawb_state_t state;
  pawb_state_t next_state;
  logic [7:0] wait_cnt; // Remaining cycles of the access
  logic [7:0] next_wait_cnt;
  // Figures kept for software to read back
  logic [7:0] last_total; // Length of the last access
  logic [7:0] next_last_total;
  logic [7:0] last_extra; // Extra waits of the last access
  logic [7:0] next_last_extra;
  // Access held steady for the peripheral side
  pawb_req_t acc; // Latched access
  pawb_req_t next_acc;
  // Next values of the registered CPU and peripheral outputs
  logic next_ready;
  logic next_done;
  logic next_periph_stb;
  logic next_stuck;

  // Calculator outputs
  // Follow the request pins; used only in the taking cycle
  // Stale while busy, which is harmless
  logic [2:0] base_m;
  logic [7:0] calc_extra;
  logic [7:0] calc_total;

  // Base wait from low bits of the setting
  // Upper setting bits are kept for read back only
  assign base_m = bus_wait_setting[PAWB_M_LSB +: PAWB_M_W];

  // Wait figures for the incoming access
  // Pure logic from request pins to counter: the longest path
  // Paid for so the access is taken the cycle it shows up
  // A registered calculator would cost one cycle per access
  pawb_kcalc u_kcalc (
    .req_i(cpu_acc_i),
    .m_i(base_m),
    .main_div_i(main_div),
    .rto_en_i(rt_output_enable_bit),
    .extra_o(calc_extra),
    .total_o(calc_total)
  );

  // Register file next values and Wishbone read mux
  // Writes land at the edge that raises ack
  // Master still holds its request then, so nothing is lost
  // Unmapped offsets read zero and drop writes
  // Still acked, so a stray access never hangs the bus
  // Unused lanes leave their bytes untouched
  always_comb begin
    next_bus_wait_setting = bus_wait_setting;
    next_main_div = main_div;
    next_rt_output_enable_bit = rt_output_enable_bit;
    next_wb_dat = 32'h0000_0000;
    // Single-cycle answer, dropped the cycle after
    // A held request is answered every other cycle, never twice in a row
    next_wb_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    if (next_wb_ack && wb_we_i) begin
      // Write only at the acked cycle
      case (wb_adr_i)
        PAWB_OFF_WAIT_SET: begin
          // Lane 0 carries the whole setting
          if (wb_sel_i[0]) begin
            next_bus_wait_setting = wb_dat_i[7:0];
          end
        end
        PAWB_OFF_CLK_CFG: begin
          if (wb_sel_i[0]) begin
            // Zero period is meaningless; keep at least one
            next_main_div = (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
          end
          // Lane 1 carries the enable bit
          if (wb_sel_i[1]) begin
            next_rt_output_enable_bit = wb_dat_i[PAWB_RTO_EN_BIT];
          end
        end
        default: begin
          // Unmapped or read-only: write ignored
        end
      endcase
    end
    // Read data muxed only while answering, zero otherwise
    if (next_wb_ack && !wb_we_i) begin
      case (wb_adr_i)
        PAWB_OFF_WAIT_SET: begin
          // Upper bits of the word read zero
          next_wb_dat = {24'h00_0000, bus_wait_setting};
        end
        PAWB_OFF_CLK_CFG: begin
          // Enable bit sits just above the clock ratio
          next_wb_dat = {23'h00_0000, rt_output_enable_bit, main_div};
        end
        PAWB_OFF_STATUS: begin
          // Live oscillator, stuck, busy and ready
          next_wb_dat = {22'h00_0000, main_osc_ok_i,
                         (state == PAWB_ST_STUCK), 6'h00,
                         (state != PAWB_ST_IDLE), cpu_ready_o};
        end
        PAWB_OFF_LAST: begin
          // Figures of the latest access taken
          next_wb_dat = {16'h0000, last_extra, last_total};
        end
        default: begin
          next_wb_dat = 32'h0000_0000; // Unmapped reads zero
        end
      endcase
    end
  end

  // Register file flops
  // Reset restores default settings
  // and silences the bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_wait_setting <= PAWB_WAIT_SET_RST;
      main_div <= PAWB_MAIN_DIV_RST;
      rt_output_enable_bit <= PAWB_RTO_EN_RST[0];
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      // Every register follows its next value on each edge
      bus_wait_setting <= next_bus_wait_setting;
      main_div <= next_main_div;
      rt_output_enable_bit <= next_rt_output_enable_bit;
      wb_dat_o <= next_wb_dat;
      wb_ack_o <= next_wb_ack;
    end
  end

  // Access engine next values
  // Access of total length T, from the edge taking the request
  // Ready falls after that edge
  // Ready rises again two cycles before the end
  // Done and peripheral strobe follow one cycle later
  // CPU sees exactly T cycles, the worst case, unless the access sticks
  // Requests seen only in idle; never queued while busy
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_last_total = last_total;
    next_last_extra = last_extra;
    next_acc = acc;
    next_ready = cpu_ready_o;
    // Done and strobe are one-cycle pulses, low unless set
    next_done = 1'b0;
    next_periph_stb = 1'b0;
    case (state)
      PAWB_ST_IDLE: begin
        if (cpu_req_i) begin
          // Load counter with access length less one
          // Latch the access for the peripheral side
          next_acc = cpu_acc_i;
          next_wait_cnt = calc_total - 8'h01;
          next_last_total = calc_total;
          next_last_extra = calc_extra;
          next_ready = 1'b0; // CPU stalled
          // Ordinary accesses need no peripheral clock
          if ((calc_extra != 8'h00) && !main_osc_ok_i) begin
            // Wait cannot complete without the peripheral clock
            next_state = PAWB_ST_STUCK;
          end else begin
            next_state = PAWB_ST_BUSY;
          end
        end
      end
      PAWB_ST_BUSY: begin
        // Ready one cycle ahead of done, so the CPU resumes on time
        if (wait_cnt <= 8'h02) begin
          next_ready = 1'b1; // Release one cycle before count end
        end
        if (wait_cnt == 8'h01) begin
          next_periph_stb = 1'b1; // Data passes the boundary
        end
        if (wait_cnt == 8'h01) begin
          next_done = 1'b1;
          next_state = PAWB_ST_IDLE;
          next_wait_cnt = 8'h00;
        end else begin
          next_wait_cnt = wait_cnt - 8'h01;
        end
      end
      PAWB_ST_STUCK: begin
        // Counter frozen; status register shows the stall
        next_ready = 1'b0; // Only reset leaves here
      end
      default: begin
        // Unused code: back to idle with the CPU released
        next_state = PAWB_ST_IDLE;
        next_ready = 1'b1;
      end
    endcase
    // Flag mirrors the state about to be entered
    next_stuck = (next_state == PAWB_ST_STUCK);
  end

  // Access engine flops
  // Reset releases the CPU and clears the stuck flag,
  // the only way out of a stalled peripheral wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PAWB_ST_IDLE;
      wait_cnt <= 8'h00;
      // Access figures read zero until the first access
      last_total <= 8'h00;
      last_extra <= 8'h00;
      acc <= '{sel: PAWB_REG_OTHER, kind: PAWB_ACC_READ};
      cpu_ready_o <= 1'b1;
      cpu_done_o <= 1'b0;
      periph_stb_o <= 1'b0;
      periph_acc_o <= '{sel: PAWB_REG_OTHER, kind: PAWB_ACC_READ};
      stuck_o <= 1'b0;
    end else begin
      // Outputs copy their next values, each from a flop
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      last_total <= next_last_total;
      last_extra <= next_last_extra;
      acc <= next_acc;
      cpu_ready_o <= next_ready;
      cpu_done_o <= next_done;
      periph_stb_o <= next_periph_stb;
      periph_acc_o <= next_acc;
      stuck_o <= next_stuck;
    end
  end

endmodule : pawb_bridge

/* File: bench/pawb_asserts.sv */
// Port checker for the access wait bridge
`timescale 1ns/1ps
module pawb_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic wb_we_i,
  input wire logic cpu_req_i,
  input wire logic cpu_ready_o,
  input wire logic cpu_done_o,
  input wire logic periph_stb_o,
  input wire logic main_osc_ok_i,
  input wire logic stuck_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Idle means ready for two cycles, not just the cycle before done
  ready_drop_a: assert property (cpu_req_i && cpu_ready_o &&
    $past(cpu_ready_o) && !stuck_o |=> !cpu_ready_o)
    else $error("ready stayed high after a taken access");
  done_shape_a: assert property (cpu_done_o |->
    $past(cpu_ready_o) && !$past(cpu_ready_o, 2))
    else $error("done without one ready cycle before it");
  done_pulse_a: assert property (cpu_done_o |=> !cpu_done_o)
    else $error("done longer than one cycle");
  stb_done_a: assert property (periph_stb_o == cpu_done_o)
    else $error("peripheral strobe apart from done");
  min_len_a: assert property ($fell(cpu_ready_o) |->
    !cpu_done_o ##1 !cpu_done_o)
    else $error("access shorter than three cycles");
  stuck_cause_a: assert property ($rose(stuck_o) |->
    !$past(main_osc_ok_i) && $past(cpu_req_i))
    else $error("stuck without an access on a stopped oscillator");
  stuck_hold_a: assert property (stuck_o |=> stuck_o && !cpu_ready_o)
    else $error("stuck state left without reset");
  stuck_quiet_a: assert property (stuck_o |-> !cpu_done_o)
    else $error("done while stuck");
  // Main scenarios reached
  cover property (cpu_done_o);
  cover property ($rose(stuck_o));
  cover property (wb_ack_o && wb_we_i);
endmodule : pawb_asserts
bind pawb_bridge pawb_asserts pawb_asserts_i (.clk_i, .rst_i, .wb_ack_o,
  .wb_we_i, .cpu_req_i, .cpu_ready_o, .cpu_done_o, .periph_stb_o,
  .main_osc_ok_i, .stuck_o);

/* File: bench/pawb_cpu_model.sv */
// CPU core stand-in issuing one peripheral access per go pulse
`timescale 1ns/1ps
module pawb_cpu_model
  import pawb_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire pawb_req_t acc_i,
  output logic cpu_req_o = 1'b0,
  output pawb_req_t cpu_acc_o = '0
);
  // Single-cycle request; access lines scrambled when not requesting
  always_ff @(posedge clk_i) begin
    cpu_req_o <= go_i;
    cpu_acc_o <= go_i ? acc_i : pawb_req_t'(~acc_i);
  end
endmodule : pawb_cpu_model

/* File: bench/tb.sv */
// Self-checking bench for the access wait bridge
`timescale 1ns/1ps
module tb;
  import pawb_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, main_osc_ok_i = 1'b1, go = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, cpu_req_i, cpu_ready_o, cpu_done_o, periph_stb_o, stuck_o;
  pawb_req_t acc = '0, cpu_acc_i, periph_acc_o, a;
  int num_errors = 0, n_checks = 0, seed = 7915;
  int m = 7, dv = 4, rt = 0, i, j, s;
  always #4 clk_i = ~clk_i;
  pawb_bridge pawb_bridge_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cpu_req_i, .cpu_acc_i, .cpu_ready_o, .cpu_done_o, .main_osc_ok_i,
    .periph_stb_o, .periph_acc_o, .stuck_o);
  pawb_cpu_model pawb_cpu_model_i (.clk_i, .go_i(go), .acc_i(acc),
    .cpu_req_o(cpu_req_i), .cpu_acc_o(cpu_acc_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // Classic single cycle, held until ack is seen
  task automatic wb(input logic we, input logic [7:0] ad, input int d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= 32'(d);
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // Fraction above 1/(2+m) rounds up
  function automatic int rnd(int num, int d);
    return num / d + ((num % d) > 1);
  endfunction : rnd
  // Expected wait factor of one access
  function automatic int kx(pawb_req_t q);
    int f2;
    int f5;
    logic w;
    f2 = rnd(2 * dv, 2 + m) + 1;
    f5 = rnd(5 * dv, 2 + m);
    w = (q.kind != PAWB_ACC_READ);
    case (q.sel)
      PAWB_REG_WDOG1_MODE: return w ? f2 : 0;
      PAWB_REG_WDOG2_MODE: return w ? 3 : 0;
      PAWB_REG_TA_CC0, PAWB_REG_TA_CC1:
        return w ? (f5 > 2 ? 2 : f5) : 1;
      PAWB_REG_TA_CNT, PAWB_REG_TWO_WIRE_ST, PAWB_REG_SER0_RX_ST,
        PAWB_REG_SER1_RX_ST: return w ? 0 : 1;
      PAWB_REG_TB_CTRL: return q.kind == PAWB_ACC_RMW;
      PAWB_REG_RT_BUF_LO, PAWB_REG_RT_BUF_HI: return w && rt == 0;
      PAWB_REG_ADC_MODE, PAWB_REG_ADC_CHSEL, PAWB_REG_ADC_CMP_MODE,
        PAWB_REG_ADC_CMP_THR: return w ? f2 : 0;
      PAWB_REG_ADC_RESULT, PAWB_REG_ADC_RESULT_HI: return w ? 0 : f2;
      default: return 0;
    endcase
  endfunction : kx
  // One CPU access; counts cycles from the taking edge to done
  task automatic run(input pawb_req_t q);
    int k;
    int t;
    int lo;
    int w;
    int p;
    k = kx(q);
    w = 3 + m + (2 + m) * k;
    s = (k > 0) && !main_osc_ok_i;
    t = 0;
    lo = 0;
    p = 0;
    @(posedge clk_i);
    go <= 1'b1;
    acc <= q;
    @(posedge clk_i);
    go <= 1'b0;
    // First loop edge is the taking edge itself
    do begin
      @(posedge clk_i);
      #1;
      t++;
      lo += !cpu_ready_o;
      p += periph_stb_o;
    end while (cpu_done_o !== 1'b1 && t < 300);
    check(32'(t), s ? 300 : w);
    check(32'(lo), s ? 300 : w - 2);
    check(stuck_o, s);
    check(32'(p), s ? 0 : 1);
    if (!s) begin
      check(periph_acc_o, q);
      wb(1'b0, PAWB_OFF_LAST, 0);
      check(rd[15:0], {8'((2 + m) * k), 8'(w)});
    end
  endtask : run
  // Watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, PAWB_OFF_WAIT_SET, 0);
    check(rd, 32'h77);
    wb(1'b0, 8'h10, 0);
    check(rd, 32'h0);
    run('{PAWB_REG_WDOG1_MODE, PAWB_ACC_WRITE});
    for (i = 0; i < 12; i++) begin
      j = $random(seed);
      m = j & 7;
      dv = ((j >> 8) & 3) + 1;
      rt = (j >> 12) & 1;
      wb(1'b1, PAWB_OFF_WAIT_SET, j & 255);
      wb(1'b1, PAWB_OFF_CLK_CFG, (rt << 8) | dv);
      wb(1'b0, PAWB_OFF_WAIT_SET, 0);
      check(rd, 32'(j & 255));
      wb(1'b0, PAWB_OFF_CLK_CFG, 0);
      check(rd, 32'((rt << 8) | dv));
      for (int r = 0; r < 18; r++) begin
        a.sel = pawb_reg_t'(5'(r));
        a.kind = pawb_acc_t'(2'($random(seed) & 1));
        if (r == 6 && (i & 1)) a.kind = PAWB_ACC_RMW;
        run(a);
      end
    end
    main_osc_ok_i <= 1'b0;
    run('{PAWB_REG_OTHER, PAWB_ACC_WRITE});
    run('{PAWB_REG_WDOG2_MODE, PAWB_ACC_WRITE});
    wb(1'b0, PAWB_OFF_STATUS, 0);
    check(rd[9:8], 2'b01);
    check(rd[1:0], 2'b10);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    main_osc_ok_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check(stuck_o, 1'b0);
    m = 7;
    dv = 4;
    rt = 0;
    run('{PAWB_REG_RT_BUF_LO, PAWB_ACC_WRITE});
    end_sim();
  end
endmodule : tb
